// ===== rtl/bdctl_board_control.sv
// board control outputs: enables, disables, timing clock and usb resets safe before power good, other device resets safe in global reset; software words otherwise
`timescale 1ns/1ps
`include "bdctl_params.svh"

module bdctl_board_control
  import bdctl_pkg::*;
#(
  parameter int FILT_CYCLES = 20000  // pushbutton settle time in clocks (1 ms at 20 MHz)
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // board state
  input  wire logic                    power_good,
  input  wire logic                    global_reset_n,
  // clock devices
  output bdctl_clk_ctl_t               clk_ctl,
  input  wire bdctl_clk_stat_t         clk_stat,
  output logic [1:0]                   clock_buffer_input_select,
  output logic                         clock_buffer_input_select_2_o,
  output logic                         clock_buffer_input_select_2_oe,
  // misc board outputs
  output logic                         memory_module_io_enable,
  output logic                         usb2_phy_reset_n,
  output logic                         usb_mux_reset,
  output logic                         cable_clock_enable_n,
  output logic                         cable_clock_select,
  input  wire logic                    cable_clock_select_switch,
  // route selection
  input  wire logic [15:0]             route_switches,
  output logic [15:0]                  route_select_line,
  // pushbuttons, pcie resets and switches toward the main fpga
  input  wire logic [1:0]              user_pushbutton,
  input  wire logic                    root_port_mode,
  input  wire logic                    cable_port_pcie_reset,
  input  wire logic                    slot_a_pcie_reset,
  input  wire logic                    slot_b_pcie_reset,
  input  wire logic                    system_switch_three,
  output logic [12:0]                  fabric_general_line
);

  // two-stage synchronisers for every pin input
  localparam int SYNC_W = 2 + 4 + 1 + 16 + 2 + 5;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  wire  [SYNC_W-1:0] pins_raw = {power_good, global_reset_n, clk_stat, cable_clock_select_switch,
                                 route_switches, user_pushbutton, root_port_mode,
                                 cable_port_pcie_reset, slot_a_pcie_reset, slot_b_pcie_reset,
                                 system_switch_three};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire             pgood_s  = sync2_q[SYNC_W-1];
  wire             grst_n_s = sync2_q[SYNC_W-2];
  bdctl_clk_stat_t stat_s;
  assign stat_s = sync2_q[SYNC_W-3 -: 4];
  wire             csel_sw_s = sync2_q[23];
  wire [15:0]      route_sw_s = sync2_q[22:7];
  wire [1:0]       pb_s       = sync2_q[6:5];
  wire             rp_mode_s  = sync2_q[4];
  wire [2:0]       perst_s    = {sync2_q[1], sync2_q[2], sync2_q[3]};  // [0] cable, [1] slot a, [2] slot b
  wire             sw3_s      = sync2_q[0];

  // software registers
  logic [`BDCTL_CTRL_W-1:0]    ctrl_q;
  logic [`BDCTL_OVR_EN_W-1:0]  ovr_en_q;
  logic [`BDCTL_OVR_VAL_W-1:0] ovr_val_q;
  logic [`BDCTL_STATUS_W-1:0]  status_q;

  // axi write: take address and data in either order, answer after both
  bdctl_wstate_t wstate_q;
  logic          aw_held_q;
  logic          w_held_q;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic [1:0]    bresp_q;
  assign s_axi_awready = (wstate_q == BDCTL_W_IDLE) && !aw_held_q;
  assign s_axi_wready  = (wstate_q == BDCTL_W_IDLE) && !w_held_q;
  assign s_axi_bvalid  = (wstate_q == BDCTL_W_RESP);
  assign s_axi_bresp   = bresp_q;

  wire        aw_have = aw_held_q || (s_axi_awvalid && s_axi_awready);
  wire        w_have  = w_held_q || (s_axi_wvalid && s_axi_wready);
  wire [7:0]  wa      = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd      = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0]  ws      = w_held_q ? wstrb_q : s_axi_wstrb;
  wire        do_wr   = (wstate_q == BDCTL_W_IDLE) && aw_have && w_have;

  // byte-lane merge, used for each writable register
  function automatic logic [31:0] bdctl_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : bdctl_merge

  function automatic logic bdctl_mapped(input logic [7:0] a);
    return (a == `BDCTL_OFF_CTRL) || (a == `BDCTL_OFF_STATUS) ||
           (a == `BDCTL_OFF_OVR_EN) || (a == `BDCTL_OFF_OVR_VAL);
  endfunction : bdctl_mapped

  wire wr_ctrl = do_wr && (wa == `BDCTL_OFF_CTRL);
  wire wr_oen  = do_wr && (wa == `BDCTL_OFF_OVR_EN);
  wire wr_ovl  = do_wr && (wa == `BDCTL_OFF_OVR_VAL);
  wire [31:0] ctrl_m = bdctl_merge({15'h0000, ctrl_q}, wd, ws);
  wire [31:0] oen_m  = bdctl_merge({15'h0000, ovr_en_q}, wd, ws);
  wire [31:0] ovl_m  = bdctl_merge({16'h0000, ovr_val_q}, wd, ws);

  // write sequencer and capture of early halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q  <= BDCTL_W_IDLE;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bresp_q   <= `BDCTL_RESP_OKAY;
    end else begin
      case (wstate_q)
        BDCTL_W_IDLE: begin
          if (do_wr) begin
            wstate_q  <= BDCTL_W_RESP;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bresp_q   <= (bdctl_mapped(wa) && wa != `BDCTL_OFF_STATUS) ? `BDCTL_RESP_OKAY
                                                                       : `BDCTL_RESP_SLVERR;
          end else begin
            if (s_axi_awvalid && s_axi_awready) begin
              aw_held_q <= 1'b1;
              awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
              w_held_q <= 1'b1;
              wdata_q  <= s_axi_wdata;
              wstrb_q  <= s_axi_wstrb;
            end
          end
        end
        BDCTL_W_RESP: begin
          if (s_axi_bready) wstate_q <= BDCTL_W_IDLE;
        end
        default: wstate_q <= BDCTL_W_IDLE;
      endcase
    end
  end

  // software words; defaults load at reset so outputs start at their default levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= `BDCTL_CTRL_RST;
      ovr_en_q  <= `BDCTL_OVR_EN_RST;
      ovr_val_q <= `BDCTL_OVR_VAL_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_m[`BDCTL_CTRL_W-1:0];
      if (wr_oen)  ovr_en_q <= oen_m[`BDCTL_OVR_EN_W-1:0];
      if (wr_ovl)  ovr_val_q <= ovl_m[`BDCTL_OVR_VAL_W-1:0];
    end
  end

  // status word samples the synchronised device pins every clock, no latching
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 4'h0;
    end else begin
      status_q[`BDCTL_ST_JC_LOL]    <= stat_s.jitter_cleaner_lock_lost;
      status_q[`BDCTL_ST_JC_IRQ]    <= stat_s.jitter_cleaner_irq_n;
      status_q[`BDCTL_ST_TCLK_LOL]  <= stat_s.timing_clock_lock_lost;
      status_q[`BDCTL_ST_SYNTH_IRQ] <= stat_s.synth_irq_n;
    end
  end

  // axi read: one outstanding, data registered with valid
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  wire [31:0] rd_mux = (s_axi_araddr == `BDCTL_OFF_CTRL)    ? {15'h0000, ctrl_q} :
                       (s_axi_araddr == `BDCTL_OFF_STATUS)  ? {28'h0000000, status_q} :
                       (s_axi_araddr == `BDCTL_OFF_OVR_EN)  ? {15'h0000, ovr_en_q} :
                       (s_axi_araddr == `BDCTL_OFF_OVR_VAL) ? {16'h0000, ovr_val_q} : 32'h00000000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `BDCTL_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= bdctl_mapped(s_axi_araddr) ? `BDCTL_RESP_OKAY : `BDCTL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // board outputs, registered: enables, disables, timing clock and usb resets safe until power good, other resets in global reset; selects, route lines not gated
  bdctl_clk_ctl_t clk_ctl_q;
  logic           memio_q;
  logic           usb2_q;
  logic           usbmux_q;
  logic           cclk_en_n_q;
  logic           cclk_sel_q;
  logic [1:0]     bufsel_q;
  logic [15:0]    route_q;
  wire  [15:0]    route_d;

  // per-line choice between software override and switch
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_route
      assign route_d[gi] = ovr_en_q[gi] ? ovr_val_q[gi] : route_sw_s[gi];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_ctl_q   <= '0;
      clk_ctl_q.jitter_cleaner_output_disable <= 1'b1;
      clk_ctl_q.clock_gen_a_output_disable    <= 1'b1;
      clk_ctl_q.clock_gen_b_output_disable    <= 1'b1;
      memio_q     <= 1'b0;
      usb2_q      <= 1'b0;
      usbmux_q    <= 1'b1;
      cclk_en_n_q <= 1'b1;
      cclk_sel_q  <= 1'b0;
      bufsel_q    <= 2'b00;
      route_q     <= 16'h0000;
    end else begin
      clk_ctl_q.clock_bus_enable_a <= pgood_s & ctrl_q[`BDCTL_B_CLK_A_EN];
      clk_ctl_q.clock_bus_enable_b <= 1'b0;
      clk_ctl_q.core_regulator_bus_enable <= pgood_s & ctrl_q[`BDCTL_B_CORE_EN];
      clk_ctl_q.synth_bus_enable <= pgood_s & ctrl_q[`BDCTL_B_SYNTH_EN];
      clk_ctl_q.jitter_cleaner_reset_n <= grst_n_s & ctrl_q[`BDCTL_B_JC_RST];
      clk_ctl_q.jitter_cleaner_output_disable <= !pgood_s | ctrl_q[`BDCTL_B_JC_OD];
      clk_ctl_q.clock_gen_a_reset_n <= grst_n_s & ctrl_q[`BDCTL_B_GEN_A_RST];
      clk_ctl_q.clock_gen_a_output_disable <= !pgood_s | ctrl_q[`BDCTL_B_GEN_A_OD];
      clk_ctl_q.clock_gen_b_reset_n <= grst_n_s & ctrl_q[`BDCTL_B_GEN_B_RST];
      clk_ctl_q.clock_gen_b_output_disable <= !pgood_s | ctrl_q[`BDCTL_B_GEN_B_OD];
      clk_ctl_q.timing_clock_reset_n <= pgood_s & ctrl_q[`BDCTL_B_TCLK_RST];
      usb2_q      <= pgood_s & ctrl_q[`BDCTL_B_USB2_RST];
      usbmux_q    <= !pgood_s | ctrl_q[`BDCTL_B_USBMUX_RST];
      cclk_en_n_q <= !pgood_s | ctrl_q[`BDCTL_B_CABLE_CLK_EN];
      memio_q     <= pgood_s;
      // no override: the select follows a board strap switch
      cclk_sel_q  <= ovr_en_q[`BDCTL_B_CABLE_OVR] ? ctrl_q[`BDCTL_B_CABLE_SEL] : csel_sw_s;
      bufsel_q    <= ctrl_q[`BDCTL_B_BUFSEL_HI:`BDCTL_B_BUFSEL_LO];
      route_q     <= route_d;
    end
  end

  assign clk_ctl                        = clk_ctl_q;
  assign memory_module_io_enable        = memio_q;
  assign usb2_phy_reset_n               = usb2_q;
  assign usb_mux_reset                  = usbmux_q;
  assign cable_clock_enable_n           = cclk_en_n_q;
  assign cable_clock_select             = cclk_sel_q;
  assign clock_buffer_input_select      = bufsel_q;
  assign clock_buffer_input_select_2_o  = 1'b0;
  assign clock_buffer_input_select_2_oe = 1'b0;
  assign route_select_line              = route_q;

  // pushbutton filter: a new level is accepted only after it holds FILT_CYCLES clocks
  logic [1:0]  pb_filt_q;
  logic [14:0] pb_cnt_q [2];
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pb
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pb_filt_q[gi] <= 1'b1;
          pb_cnt_q[gi]  <= 15'h0000;
        end else if (pb_s[gi] == pb_filt_q[gi]) begin
          pb_cnt_q[gi] <= 15'h0000;
        end else if (pb_cnt_q[gi] == 15'(FILT_CYCLES - 1)) begin
          pb_filt_q[gi] <= pb_s[gi];
          pb_cnt_q[gi]  <= 15'h0000;
        end else begin
          pb_cnt_q[gi] <= pb_cnt_q[gi] + 15'h0001;
        end
      end
    end
  endgenerate

  // fabric lines; pcie resets are passed only in root port mode, lines 6..12 read zero
  logic [12:0] fab_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fab_q <= 13'h0003;
    end else begin
      fab_q[1:0]  <= pb_filt_q;
      fab_q[4:2]  <= rp_mode_s ? perst_s : 3'b000;
      fab_q[5]    <= sw3_s;
      fab_q[12:6] <= 7'h00;
    end
  end
  assign fabric_general_line = fab_q;

  // checks
  a_clk_a_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !sync2_q[SYNC_W-1] |=> !clk_ctl.clock_bus_enable_a)
    else $error("clock bus enable A high before power good");
  a_core_en: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(pgood_s) && pgood_s |-> clk_ctl.core_regulator_bus_enable == $past(ctrl_q[1]))
    else $error("core regulator enable does not follow control bit");
  a_jc_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    !grst_n_s |=> !clk_ctl.jitter_cleaner_reset_n)
    else $error("jitter cleaner reset released during global reset");
  a_od_safe: assert property (@(posedge aclk) disable iff (!aresetn)
    !pgood_s |=> clk_ctl.clock_gen_a_output_disable && clk_ctl.clock_gen_b_output_disable)
    else $error("output disable low before power good");
  a_usbmux: assert property (@(posedge aclk) disable iff (!aresetn)
    !pgood_s |=> usb_mux_reset && !usb2_phy_reset_n)
    else $error("usb resets wrong before power good");
  a_route_ovr: assert property (@(posedge aclk) disable iff (!aresetn)
    ovr_en_q[0] |=> route_select_line[0] == $past(ovr_val_q[0]))
    else $error("route select 0 ignores override");
  a_route_sw: assert property (@(posedge aclk) disable iff (!aresetn)
    !ovr_en_q[15] |=> route_select_line[15] == $past(route_sw_s[15]))
    else $error("route select 15 ignores switch");
  a_stat_lol: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_s.jitter_cleaner_lock_lost |=> status_q[3])
    else $error("lock lost not recorded");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 fabric_general_line[12:6] == 7'h00)
    else $error("reserved fabric lines driven");
  a_memio: assert property (@(posedge aclk) disable iff (!aresetn)
    pgood_s ##1 pgood_s |-> memory_module_io_enable)
    else $error("memory io enable low after power good");
  a_ctrl_reset: assert property (@(posedge aclk) $rose(aresetn) |-> ctrl_q == `BDCTL_CTRL_RST)
    else $error("control word reset value wrong");

  c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_ctrl ##[1:4] s_axi_bvalid);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
  c_override: cover property (@(posedge aclk) disable iff (!aresetn) $rose(ovr_en_q[16]));
  c_pgood: cover property (@(posedge aclk) disable iff (!aresetn) $rose(pgood_s));

endmodule : bdctl_board_control

// ===== rtl/bdctl_params.svh
// register offsets, field positions and reset values of the board control block
`ifndef BDCTL_PARAMS_SVH
`define BDCTL_PARAMS_SVH

`define BDCTL_ADDR_W         8
`define BDCTL_OFF_CTRL       8'h00
`define BDCTL_OFF_STATUS     8'h04
`define BDCTL_OFF_OVR_EN     8'h08
`define BDCTL_OFF_OVR_VAL    8'h0C
`define BDCTL_CTRL_W         17
`define BDCTL_STATUS_W       4
`define BDCTL_OVR_EN_W       17
`define BDCTL_OVR_VAL_W      16
// control word reset: bits 2,1,13,9,11,15,6 set; all others clear
`define BDCTL_CTRL_RST       17'h0AA46
`define BDCTL_OVR_EN_RST     17'h00000
`define BDCTL_OVR_VAL_RST    16'h0000
`define BDCTL_B_CORE_EN      1
`define BDCTL_B_CLK_A_EN     2
`define BDCTL_B_SYNTH_EN     3
`define BDCTL_B_BUFSEL_LO    4
`define BDCTL_B_BUFSEL_HI    5
`define BDCTL_B_TCLK_RST     6
`define BDCTL_B_CABLE_CLK_EN 7
`define BDCTL_B_CABLE_SEL    8
`define BDCTL_B_GEN_A_RST    9
`define BDCTL_B_GEN_A_OD     10
`define BDCTL_B_GEN_B_RST    11
`define BDCTL_B_GEN_B_OD     12
`define BDCTL_B_JC_RST       13
`define BDCTL_B_JC_OD        14
`define BDCTL_B_USB2_RST     15
`define BDCTL_B_USBMUX_RST   16
`define BDCTL_B_CABLE_OVR    16
`define BDCTL_ST_SYNTH_IRQ   0
`define BDCTL_ST_TCLK_LOL    1
`define BDCTL_ST_JC_IRQ      2
`define BDCTL_ST_JC_LOL      3
`define BDCTL_RESP_OKAY      2'h0
`define BDCTL_RESP_SLVERR    2'h2

`endif

// ===== rtl/bdctl_pkg.sv
// types shared by the board control block
package bdctl_pkg;
  // clock device control outputs, grouped
  typedef struct packed {
    logic clock_bus_enable_a;
    logic clock_bus_enable_b;
    logic core_regulator_bus_enable;
    logic synth_bus_enable;
    logic jitter_cleaner_reset_n;
    logic jitter_cleaner_output_disable;
    logic clock_gen_a_reset_n;
    logic clock_gen_a_output_disable;
    logic clock_gen_b_reset_n;
    logic clock_gen_b_output_disable;
    logic timing_clock_reset_n;
  } bdctl_clk_ctl_t;

  // raw status inputs from clock devices
  typedef struct packed {
    logic jitter_cleaner_lock_lost;
    logic jitter_cleaner_irq_n;
    logic timing_clock_lock_lost;
    logic synth_irq_n;
  } bdctl_clk_stat_t;

  // write channel sequencer states
  typedef enum logic [1:0] {
    BDCTL_W_IDLE = 2'b00,
    BDCTL_W_RESP = 2'b01
  } bdctl_wstate_t;
endpackage : bdctl_pkg

// ===== verification/bdctl_board_model.sv
// far-side model: clock devices, interrupt pins
`timescale 1ns/1ps
module bdctl_board_model
  import bdctl_pkg::*;
(
  // controls from the block
  input  wire bdctl_clk_ctl_t clk_ctl,
  // interrupt levels chosen by the bench
  input  wire logic [1:0]     irq_n,
  // status pins back to the block
  output bdctl_clk_stat_t     clk_stat
);
  // a device held in reset cannot be locked, so lock loss follows its reset
  assign clk_stat.jitter_cleaner_lock_lost = ~clk_ctl.jitter_cleaner_reset_n;
  assign clk_stat.jitter_cleaner_irq_n     = irq_n[1];
  assign clk_stat.timing_clock_lock_lost   = ~clk_ctl.timing_clock_reset_n;
  assign clk_stat.synth_irq_n              = irq_n[0];
endmodule : bdctl_board_model

// ===== verification/bdctl_board_control_test.sv
// self-checking bench for the board control block
`timescale 1ns/1ps
`include "bdctl_params.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, s); end end
module bdctl_board_control_test
  import bdctl_pkg::*;
;
  localparam logic [16:0] DEF = `BDCTL_CTRL_RST;
  localparam logic [16:0] INV = 17'h155B9;
  int err_total = 0;
  int n_compared = 0;
  logic aclk = 1'b0, aresetn = 1'b0, pwr = 1'b0, glob_rst_n = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic root = 1'b0, cpr = 1'b0, sar = 1'b0, sbr = 1'b0, sw3 = 1'b0, csw = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdv;
  logic [15:0] rsw = 16'hA5C3;
  logic [1:0] pb = 2'h3, irq_n = 2'h3, resp;
  wire awr, wr_rdy, bv, arr, rv, b2o, b2oe, mio, usb2, umr, cen, csel;
  wire [1:0] br, rr, bsel;
  wire [31:0] rd_data;
  wire [15:0] rsel;
  wire [12:0] fab;
  bdctl_clk_ctl_t ctl;
  bdctl_clk_stat_t st;

  // short filter so button changes settle quickly
  bdctl_board_control #(.FILT_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_data), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .power_good(pwr), .global_reset_n(glob_rst_n), .clk_ctl(ctl), .clk_stat(st),
    .clock_buffer_input_select(bsel), .clock_buffer_input_select_2_o(b2o), .clock_buffer_input_select_2_oe(b2oe),
    .memory_module_io_enable(mio), .usb2_phy_reset_n(usb2), .usb_mux_reset(umr), .cable_clock_enable_n(cen),
    .cable_clock_select(csel), .cable_clock_select_switch(csw), .route_switches(rsw), .route_select_line(rsel),
    .user_pushbutton(pb), .root_port_mode(root), .cable_port_pcie_reset(cpr), .slot_a_pcie_reset(sar),
    .slot_b_pcie_reset(sbr), .system_switch_three(sw3), .fabric_general_line(fab));
  bdctl_board_model far (.clk_ctl(ctl), .irq_n(irq_n), .clk_stat(st));

  // clock-device outputs expected once power is good and global reset is off
  function automatic logic [10:0] exp_ctl(input logic [16:0] c);
    return {c[2], 1'b0, c[1], c[3], c[13], c[14], c[9], c[10], c[11], c[12], c[6]};
  endfunction : exp_ctl
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle
  // bready is held high, so the answer is taken at the edge that shows bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    resp = br;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rdv = rd_data;
    resp = rr;
  endtask : rd
  task automatic t_safe;
    settle(3);
    `CHK("ctl", 11'h07E, ctl)
    `CHK("misc", 4'h3, {mio, usb2, umr, cen})
    rd(`BDCTL_OFF_CTRL);
    `CHK("ctrl", {15'h0, DEF}, rdv)
    rd(`BDCTL_OFF_STATUS);
    `CHK("stat", 32'h7, rdv)
  endtask : t_safe
  task automatic t_power;
    @(posedge aclk);
    pwr <= 1'b1;
    settle(4);
    `CHK("ctl", exp_ctl(DEF), ctl)
    `CHK("misc", 8'hC0, {mio, usb2, umr, cen, bsel, b2o, b2oe})
    wr(`BDCTL_OFF_CTRL, {15'h0, INV});
    settle(2);
    `CHK("ctl", exp_ctl(INV), ctl)
    `CHK("misc", {INV[15], INV[16], INV[7], INV[5:4]}, {usb2, umr, cen, bsel})
    wr(`BDCTL_OFF_CTRL, {15'h0, DEF});
  endtask : t_power
  task automatic t_grst;
    @(posedge aclk);
    glob_rst_n <= 1'b0;
    irq_n <= 2'b10;
    // lock loss comes back through the model and two synchroniser stages
    settle(8);
    `CHK("ctl", exp_ctl(DEF) & 11'h7AB, ctl)
    rd(`BDCTL_OFF_STATUS);
    `CHK("stat", 32'hC, rdv)
    glob_rst_n <= 1'b1;
    irq_n <= 2'b01;
    settle(8);
    rd(`BDCTL_OFF_STATUS);
    `CHK("stat", 32'h1, rdv)
  endtask : t_grst
  task automatic t_route;
    wr(`BDCTL_OFF_OVR_EN, 32'h100FF);
    wr(`BDCTL_OFF_OVR_VAL, 32'h1234);
    wr(`BDCTL_OFF_CTRL, {15'h0, DEF | 17'h00100});
    settle(2);
    `CHK("route", 17'h1A534, {csel, rsel})
    @(posedge aclk);
    csw <= 1'b1;
    wr(`BDCTL_OFF_OVR_EN, 32'h0);
    settle(2);
    `CHK("route", 17'h1A5C3, {csel, rsel})
    wr(`BDCTL_OFF_STATUS, 32'hF);
    `CHK("bresp", `BDCTL_RESP_SLVERR, resp)
    rd(8'h10);
    `CHK("rd", {`BDCTL_RESP_SLVERR, 32'h0}, {resp, rdv})
  endtask : t_route
  task automatic t_fabric;
    @(posedge aclk);
    // slot b stays low so a swapped cable/slot b order shows up
    {pb, root, cpr, sar, sbr, sw3} <= 7'b0111101;
    settle(20);
    `CHK("fab", 13'h002D, fab)
    @(posedge aclk);
    root <= 1'b0;
    settle(4);
    `CHK("fab", 13'h0021, fab)
  endtask : t_fabric
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // clock, main sequence and watchdog
  initial begin
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_safe();
    t_power();
    t_grst();
    t_route();
    t_fabric();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
endmodule : bdctl_board_control_test
